// File: hw/exec_regs.svh
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

// data path and field widths
`define DATA_WIDTH 8
`define PROGRAM_COUNTER_WIDTH 16
`define OFFSET_WIDTH 7
`define IO_ADDR_WIDTH 5
`define BIT_SEL_WIDTH 3
`define REG_ADDR_WIDTH 5

// field positions inside the data byte
`define DATA_MSB 7
`define DATA_LSB 0

// reset values of the result registers
`define PROGRAM_COUNTER_RESET 16'h0000
`define DATA_RESET 8'h00

// cycles each instruction occupies the unit
`define BRANCH_NOT_TAKEN_CYCLES 1
`define BRANCH_TAKEN_CYCLES 2
`define IO_BIT_CYCLES 2
`define SHIFT_CYCLES 1

`endif

// File: hw/exec_pkg.sv
`include "exec_regs.svh"

package exec_pkg;

	// operations this unit executes
	typedef enum logic [3:0] {
		op_none,
		op_branch_on_overflow_set,
		op_branch_on_overflow_clear,
		op_branch_if_irq_enabled,
		op_branch_if_irq_disabled,
		op_io_bit_set,
		op_io_bit_clear,
		op_shift_left_logical,
		op_shift_right_logical
	} op_t;

	// decoded instruction as handed over by the decoder
	typedef struct packed {
		op_t op;
		logic [`OFFSET_WIDTH-1:0] offset;
		logic [`IO_ADDR_WIDTH-1:0] io_addr;
		logic [`BIT_SEL_WIDTH-1:0] bit_sel;
		logic [`REG_ADDR_WIDTH-1:0] reg_addr;
	} instr_t;

	// status flags written by the shifts
	typedef struct packed {
		logic z;
		logic c;
		logic n;
		logic v;
	} flags_t;

endpackage : exec_pkg

// File: hw/shift_unit.sv
`timescale 1ns/1ps
`include "exec_regs.svh"

// one-place logical shift with its status flags
module shift_unit (
	input wire logic [`DATA_WIDTH-1:0] operand,
	input wire logic shift_left,
	output logic [`DATA_WIDTH-1:0] result,
	output exec_pkg::flags_t flags
);

	// shift in zero, carry takes the bit shifted out
	always_comb
	begin
		if (shift_left)
		begin
			result = {operand[`DATA_MSB-1:`DATA_LSB], 1'b0};
			flags.c = operand[`DATA_MSB];
		end
		else
		begin
			result = {1'b0, operand[`DATA_MSB:`DATA_LSB+1]};
			flags.c = operand[`DATA_LSB];
		end
		flags.z = (result == `DATA_RESET);
		flags.n = result[`DATA_MSB];
		flags.v = flags.n ^ flags.c;
	end

endmodule : shift_unit

// File: hw/branch_bitop_shift_exec.sv
`timescale 1ns/1ps
`include "exec_regs.svh"

// Operation
// - overflow set: counter gets counter+offset+1
// - overflow clear: counter gets counter+offset+1
// - irq enabled: counter gets counter+offset+1
// - irq disabled: counter gets counter+offset+1
// - io bit set, others kept, two cycles
// - io bit clear, others kept, two cycles
// - shift left, zero into bit 0, flags
// - shift right, zero into bit 7, flags
module branch_bitop_shift_exec (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic instr_valid,
	input wire exec_pkg::instr_t instr,
	output logic instr_ready,
	input wire logic [`PROGRAM_COUNTER_WIDTH-1:0] program_counter_value,
	input wire logic flag_overflow,
	input wire logic flag_irq_enable,
	input wire logic [`DATA_WIDTH-1:0] reg_read_data,
	output logic io_rd_en,
	output logic [`IO_ADDR_WIDTH-1:0] io_rd_addr,
	input wire logic [`DATA_WIDTH-1:0] io_rd_data,
	output logic program_counter_load,
	output logic [`PROGRAM_COUNTER_WIDTH-1:0] program_counter_target,
	output logic io_wr_en,
	output logic [`IO_ADDR_WIDTH-1:0] io_wr_addr,
	output logic [`DATA_WIDTH-1:0] io_wr_data,
	output logic reg_wr_en,
	output logic [`REG_ADDR_WIDTH-1:0] reg_wr_addr,
	output logic [`DATA_WIDTH-1:0] reg_wr_data,
	output logic flag_wr_en,
	output exec_pkg::flags_t flags_out
);

	typedef enum logic [1:0] {
		st_idle,
		st_branch_wait,
		st_io_modify
	} state_t;

	state_t state_r, state_nxt;
	logic take;
	logic branch_taken;
	logic is_branch;
	logic [`PROGRAM_COUNTER_WIDTH-1:0] branch_target;
	logic [`DATA_WIDTH-1:0] shift_result;
	exec_pkg::flags_t shift_flags;
	logic [`DATA_WIDTH-1:0] bit_mask;
	logic [`BIT_SEL_WIDTH-1:0] bit_sel_r, bit_sel_nxt;
	logic bit_set_r, bit_set_nxt;
	logic [`IO_ADDR_WIDTH-1:0] io_addr_r, io_addr_nxt;
	logic pc_load_r, pc_load_nxt;
	logic [`PROGRAM_COUNTER_WIDTH-1:0] target_r, target_nxt;
	logic io_wr_en_r, io_wr_en_nxt;
	logic [`DATA_WIDTH-1:0] io_wr_data_r, io_wr_data_nxt;
	logic reg_wr_en_r, reg_wr_en_nxt;
	logic [`REG_ADDR_WIDTH-1:0] reg_wr_addr_r, reg_wr_addr_nxt;
	logic [`DATA_WIDTH-1:0] reg_wr_data_r, reg_wr_data_nxt;
	logic flag_wr_en_r, flag_wr_en_nxt;
	exec_pkg::flags_t flags_r, flags_nxt;

	// handshake: new work only while idle
	assign instr_ready = (state_r == st_idle);
	assign take = instr_valid && instr_ready;
	assign is_branch = (instr.op == exec_pkg::op_branch_on_overflow_set)
		|| (instr.op == exec_pkg::op_branch_on_overflow_clear)
		|| (instr.op == exec_pkg::op_branch_if_irq_enabled)
		|| (instr.op == exec_pkg::op_branch_if_irq_disabled);

	// io read issued in the take cycle, data returns one cycle later
	assign io_rd_en = take && ((instr.op == exec_pkg::op_io_bit_set)
		|| (instr.op == exec_pkg::op_io_bit_clear));
	assign io_rd_addr = instr.io_addr;

	// relative target: counter plus sign-extended offset plus one
	assign branch_target = `PROGRAM_COUNTER_WIDTH'(program_counter_value
		+ {{(`PROGRAM_COUNTER_WIDTH-`OFFSET_WIDTH){instr.offset[`OFFSET_WIDTH-1]}},
		instr.offset} + `PROGRAM_COUNTER_WIDTH'(1));

	// branch condition per operation
	always_comb
	begin
		case (instr.op)
			exec_pkg::op_branch_on_overflow_set: branch_taken = flag_overflow;
			exec_pkg::op_branch_on_overflow_clear: branch_taken = !flag_overflow;
			exec_pkg::op_branch_if_irq_enabled: branch_taken = flag_irq_enable;
			exec_pkg::op_branch_if_irq_disabled: branch_taken = !flag_irq_enable;
			default: branch_taken = 1'b0;
		endcase
	end

	// selected-bit mask, one decoder per bit
	genvar g;
	generate
		for (g = 0; g < `DATA_WIDTH; g++)
		begin : gen_mask
			assign bit_mask[g] = (bit_sel_r == `BIT_SEL_WIDTH'(g));
		end
	endgenerate

	shift_unit shift_unit_inst (
		.operand(reg_read_data),
		.shift_left(instr.op == exec_pkg::op_shift_left_logical),
		.result(shift_result),
		.flags(shift_flags)
	);

	// next state and result values
	always_comb
	begin
		state_nxt = state_r;
		bit_sel_nxt = bit_sel_r;
		bit_set_nxt = bit_set_r;
		io_addr_nxt = io_addr_r;
		target_nxt = target_r;
		io_wr_data_nxt = io_wr_data_r;
		reg_wr_addr_nxt = reg_wr_addr_r;
		reg_wr_data_nxt = reg_wr_data_r;
		flags_nxt = flags_r;
		pc_load_nxt = 1'b0;
		io_wr_en_nxt = 1'b0;
		reg_wr_en_nxt = 1'b0;
		flag_wr_en_nxt = 1'b0;
		case (state_r)
			st_idle:
			begin
				if (take)
				begin
					case (instr.op)
						exec_pkg::op_branch_on_overflow_set,
						exec_pkg::op_branch_on_overflow_clear,
						exec_pkg::op_branch_if_irq_enabled,
						exec_pkg::op_branch_if_irq_disabled:
						begin
							// taken branch holds one extra cycle; flags untouched
							if (branch_taken)
							begin
								pc_load_nxt = 1'b1;
								target_nxt = branch_target;
								state_nxt = st_branch_wait;
							end
						end
						exec_pkg::op_io_bit_set,
						exec_pkg::op_io_bit_clear:
						begin
							io_addr_nxt = instr.io_addr;
							bit_sel_nxt = instr.bit_sel;
							bit_set_nxt = (instr.op == exec_pkg::op_io_bit_set);
							state_nxt = st_io_modify;
						end
						exec_pkg::op_shift_left_logical,
						exec_pkg::op_shift_right_logical:
						begin
							reg_wr_en_nxt = 1'b1;
							reg_wr_addr_nxt = instr.reg_addr;
							reg_wr_data_nxt = shift_result;
							flag_wr_en_nxt = 1'b1;
							flags_nxt = shift_flags;
						end
						default:
						begin
							state_nxt = st_idle;
						end
					endcase
				end
			end
			st_branch_wait:
			begin
				state_nxt = st_idle;
			end
			st_io_modify:
			begin
				// read-modify-write keeps all other bits
				io_wr_en_nxt = 1'b1;
				if (bit_set_r)
					io_wr_data_nxt = io_rd_data | bit_mask;
				else
					io_wr_data_nxt = io_rd_data & ~bit_mask;
				state_nxt = st_idle;
			end
			default:
			begin
				state_nxt = st_idle;
			end
		endcase
	end

	// register all state and results
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_r <= st_idle;
			bit_sel_r <= '0;
			bit_set_r <= 1'b0;
			io_addr_r <= '0;
			pc_load_r <= 1'b0;
			target_r <= `PROGRAM_COUNTER_RESET;
			io_wr_en_r <= 1'b0;
			io_wr_data_r <= `DATA_RESET;
			reg_wr_en_r <= 1'b0;
			reg_wr_addr_r <= '0;
			reg_wr_data_r <= `DATA_RESET;
			flag_wr_en_r <= 1'b0;
			flags_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			bit_sel_r <= bit_sel_nxt;
			bit_set_r <= bit_set_nxt;
			io_addr_r <= io_addr_nxt;
			pc_load_r <= pc_load_nxt;
			target_r <= target_nxt;
			io_wr_en_r <= io_wr_en_nxt;
			io_wr_data_r <= io_wr_data_nxt;
			reg_wr_en_r <= reg_wr_en_nxt;
			reg_wr_addr_r <= reg_wr_addr_nxt;
			reg_wr_data_r <= reg_wr_data_nxt;
			flag_wr_en_r <= flag_wr_en_nxt;
			flags_r <= flags_nxt;
		end
	end

	// outputs straight from registers
	assign program_counter_load = pc_load_r;
	assign program_counter_target = target_r;
	assign io_wr_en = io_wr_en_r;
	assign io_wr_addr = io_addr_r;
	assign io_wr_data = io_wr_data_r;
	assign reg_wr_en = reg_wr_en_r;
	assign reg_wr_addr = reg_wr_addr_r;
	assign reg_wr_data = reg_wr_data_r;
	assign flag_wr_en = flag_wr_en_r;
	assign flags_out = flags_r;

	// checks on the executed behaviour
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_ovf_set_branch: assert property (
		take && instr.op == exec_pkg::op_branch_on_overflow_set
		|=> (program_counter_load == $past(flag_overflow))
		&& (!$past(flag_overflow) || program_counter_target == $past(branch_target)))
		else $error("overflow-set branch wrong");
	a_ovf_clear_branch: assert property (
		take && instr.op == exec_pkg::op_branch_on_overflow_clear
		|=> program_counter_load == !$past(flag_overflow))
		else $error("overflow-clear branch wrong");
	a_irq_en_branch: assert property (
		take && instr.op == exec_pkg::op_branch_if_irq_enabled
		|=> program_counter_load == $past(flag_irq_enable))
		else $error("irq-enabled branch wrong");
	a_irq_dis_branch: assert property (
		take && instr.op == exec_pkg::op_branch_if_irq_disabled
		|=> program_counter_load == !$past(flag_irq_enable))
		else $error("irq-disabled branch wrong");
	a_branch_cycle_count: assert property (
		take && is_branch && branch_taken
		|=> !instr_ready && !flag_wr_en ##1 instr_ready && !program_counter_load)
		else $error("taken branch not two cycles");
	a_branch_not_taken: assert property (
		take && is_branch && !branch_taken
		|=> instr_ready && !program_counter_load && !flag_wr_en)
		else $error("untaken branch not one cycle");
	a_io_bit_set: assert property (
		take && instr.op == exec_pkg::op_io_bit_set
		|=> !instr_ready ##1 io_wr_en && instr_ready && !flag_wr_en
		&& io_wr_data == ($past(io_rd_data) | (`DATA_WIDTH'(1) << $past(instr.bit_sel, 2))))
		else $error("io bit set wrong");
	a_io_bit_clear: assert property (
		take && instr.op == exec_pkg::op_io_bit_clear
		|=> !instr_ready ##1 io_wr_en && io_wr_addr == $past(io_rd_addr, 2)
		&& io_wr_data == ($past(io_rd_data) & ~(`DATA_WIDTH'(1) << $past(instr.bit_sel, 2))))
		else $error("io bit clear wrong");
	a_shift_left: assert property (
		take && instr.op == exec_pkg::op_shift_left_logical
		|=> reg_wr_en && flag_wr_en && instr_ready
		&& flags_out.c == $past(reg_read_data[`DATA_MSB])
		&& reg_wr_data == {$past(reg_read_data[`DATA_MSB-1:`DATA_LSB]), 1'b0})
		else $error("left shift wrong");
	a_shift_right: assert property (
		take && instr.op == exec_pkg::op_shift_right_logical
		|=> reg_wr_en && flag_wr_en
		&& flags_out.c == $past(reg_read_data[`DATA_LSB])
		&& reg_wr_data == {1'b0, $past(reg_read_data[`DATA_MSB:`DATA_LSB+1])})
		else $error("right shift wrong");
	a_shift_flags: assert property (
		flag_wr_en |-> flags_out.v == (flags_out.n ^ flags_out.c)
		&& flags_out.z == (reg_wr_data == `DATA_RESET)
		&& flags_out.n == reg_wr_data[`DATA_MSB])
		else $error("shift flags wrong");
	c_branch_taken: cover property (take && is_branch && branch_taken);
	c_branch_untaken: cover property (take && is_branch && !branch_taken);
	c_io_write: cover property (io_wr_en);
	c_shift_carry: cover property (flag_wr_en && flags_out.c);
endmodule : branch_bitop_shift_exec

// File: bench/tb_branch_bitop_shift_exec.sv
`timescale 1ns/1ps
`include "exec_regs.svh"

// compares one value and reports a mismatch at once
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fail_count++; \
	$display("BAD %s expected %h seen %h", nm, ex, got); end end

module tb_branch_bitop_shift_exec;
	logic clk_sys;
	logic reset;
	logic instr_valid;
	exec_pkg::instr_t instr;
	logic instr_ready;
	logic [15:0] program_counter_value;
	logic flag_overflow;
	logic flag_irq_enable;
	logic [7:0] reg_read_data;
	logic io_rd_en;
	logic [4:0] io_rd_addr;
	logic [7:0] io_rd_data;
	logic program_counter_load;
	logic [15:0] program_counter_target;
	logic io_wr_en;
	logic [4:0] io_wr_addr;
	logic [7:0] io_wr_data;
	logic reg_wr_en;
	logic [4:0] reg_wr_addr;
	logic [7:0] reg_wr_data;
	logic flag_wr_en;
	exec_pkg::flags_t flags_out;
	int fail_count;
	int n_compared;

	branch_bitop_shift_exec branch_bitop_shift_exec_inst (
		.clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .program_counter_value(program_counter_value),
		.flag_overflow(flag_overflow), .flag_irq_enable(flag_irq_enable),
		.reg_read_data(reg_read_data), .io_rd_en(io_rd_en), .io_rd_addr(io_rd_addr),
		.io_rd_data(io_rd_data), .program_counter_load(program_counter_load),
		.program_counter_target(program_counter_target), .io_wr_en(io_wr_en),
		.io_wr_addr(io_wr_addr), .io_wr_data(io_wr_data), .reg_wr_en(reg_wr_en),
		.reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .flag_wr_en(flag_wr_en),
		.flags_out(flags_out)
	);

	// 25 MHz core clock
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// prints the counts and the verdict, then stops
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	// expected shift result and flags {z,c,n,v}
	function automatic logic [11:0] shift_exp(input logic left, input logic [7:0] d);
		logic [7:0] r;
		logic c;
		r = left ? {d[6:0], 1'b0} : {1'b0, d[7:1]};
		c = left ? d[7] : d[0];
		return {r, r == 8'h00, c, r[7], r[7] ^ c};
	endfunction : shift_exp

	// presents one instruction and returns just after the edge that takes it
	task automatic take(input exec_pkg::op_t op, input logic [6:0] off, input logic [2:0] bs,
		input logic [15:0] pc, input logic v, input logic ie, input logic [7:0] rd);
		logic is_io;
		is_io = (op == exec_pkg::op_io_bit_set) || (op == exec_pkg::op_io_bit_clear);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr <= {op, off, 5'h13, bs, 5'h0b};
		program_counter_value <= pc;
		flag_overflow <= v;
		flag_irq_enable <= ie;
		reg_read_data <= rd;
		io_rd_data <= rd;
		#1;
		`CHK("ready", 1'b1, instr_ready)
		`CHK("io_rd_en", is_io, io_rd_en)
		`CHK("io_rd_addr", 5'h13, io_rd_addr)
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		reg_read_data <= ~rd;
		program_counter_value <= ~pc;
		#1;
	endtask : take

	// every branch kind, with its condition met and not met
	task automatic test_branches;
		logic [6:0] off_tab [4] = '{7'h3f, 7'h40, 7'h7f, 7'h00};
		logic [15:0] pc_tab [4] = '{16'hffff, 16'h0010, 16'h1234, 16'h8000};
		logic cond;
		logic taken;
		logic [15:0] tgt;
		for (int k = 0; k < 8; k++)
		begin
			cond = k[0];
			taken = cond ^ k[1];
			tgt = pc_tab[k/2] + {{9{off_tab[k/2][6]}}, off_tab[k/2]} + 16'h0001;
			take(exec_pkg::op_t'(4'h1 + k/2), off_tab[k/2], 3'h0, pc_tab[k/2],
				(k < 4) ? cond : ~cond, (k < 4) ? ~cond : cond, 8'h00);
			`CHK("pc_load", taken, program_counter_load)
			`CHK("ready_c1", ~taken, instr_ready)
			`CHK("flag_wr", 1'b0, flag_wr_en)
			if (taken)
			begin
				`CHK("target", tgt, program_counter_target)
				@(posedge clk_sys);
				#1;
				`CHK("pc_load_c2", 1'b0, program_counter_load)
				`CHK("ready_c2", 1'b1, instr_ready)
			end
		end
		$display("test branches done");
	endtask : test_branches

	// set on the odd bits and clear on the even bits, the other bits kept
	task automatic test_io_bits;
		logic set;
		logic [7:0] mask;
		logic [7:0] rd;
		for (int b = 0; b < 8; b++)
		begin
			set = b[0];
			mask = 8'h01 << b;
			rd = set ? (~mask & 8'hc3) : (mask | 8'h3c);
			take(set ? exec_pkg::op_io_bit_set : exec_pkg::op_io_bit_clear, 7'h00, b[2:0],
				16'h0000, 1'b0, 1'b0, rd);
			`CHK("ready_c1", 1'b0, instr_ready)
			`CHK("io_wr_c1", 1'b0, io_wr_en)
			@(posedge clk_sys);
			io_rd_data <= ~rd;
			#1;
			`CHK("io_wr_en", 1'b1, io_wr_en)
			`CHK("io_wr_addr", 5'h13, io_wr_addr)
			`CHK("io_wr_data", set ? (rd | mask) : (rd & ~mask), io_wr_data)
			`CHK("flag_wr", 1'b0, flag_wr_en)
			`CHK("ready_c2", 1'b1, instr_ready)
		end
		$display("test io bits done");
	endtask : test_io_bits

	// both shifts over edge values, result and flags
	task automatic test_shifts;
		logic [7:0] val_tab [5] = '{8'h80, 8'h01, 8'h41, 8'h00, 8'hff};
		logic [11:0] ex;
		for (int k = 0; k < 10; k++)
		begin
			ex = shift_exp(k[0], val_tab[k/2]);
			take(k[0] ? exec_pkg::op_shift_left_logical : exec_pkg::op_shift_right_logical,
				7'h00, 3'h0, 16'h0000, 1'b0, 1'b0, val_tab[k/2]);
			`CHK("reg_wr_en", 1'b1, reg_wr_en)
			`CHK("reg_wr_addr", 5'h0b, reg_wr_addr)
			`CHK("reg_wr_data", ex[11:4], reg_wr_data)
			`CHK("flag_wr_en", 1'b1, flag_wr_en)
			`CHK("flags", ex[3:0], flags_out)
			`CHK("ready_c1", 1'b1, instr_ready)
		end
		$display("test shifts done");
	endtask : test_shifts

	// the empty operation is taken and leaves every output alone
	task automatic test_op_none;
		take(exec_pkg::op_none, 7'h05, 3'h1, 16'h0100, 1'b1, 1'b1, 8'h81);
		`CHK("none_pc_load", 1'b0, program_counter_load)
		`CHK("none_io_wr", 1'b0, io_wr_en)
		`CHK("none_reg_wr", 1'b0, reg_wr_en)
		`CHK("none_flag_wr", 1'b0, flag_wr_en)
		`CHK("none_ready", 1'b1, instr_ready)
		$display("test op none done");
	endtask : test_op_none

	// reset in mid-run clears the held results, work resumes after it
	task automatic test_reset_mid;
		take(exec_pkg::op_shift_left_logical, 7'h00, 3'h0, 16'h0000, 1'b0, 1'b0, 8'hc1);
		`CHK("pre_rst_data", 8'h82, reg_wr_data)
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		`CHK("rst_data", 8'h00, reg_wr_data)
		`CHK("rst_flags", 4'h0, flags_out)
		`CHK("rst_flag_wr", 1'b0, flag_wr_en)
		`CHK("rst_ready", 1'b1, instr_ready)
		take(exec_pkg::op_shift_right_logical, 7'h00, 3'h0, 16'h0000, 1'b0, 1'b0, 8'h03);
		`CHK("post_rst_data", 8'h01, reg_wr_data)
		`CHK("post_rst_flags", 4'h5, flags_out)
		$display("test reset mid done");
	endtask : test_reset_mid

	// cuts a hang short
	initial
	begin
		repeat (3000) @(posedge clk_sys);
		fail_count++;
		summarize();
	end

	// reset, then the scenarios
	initial
	begin
		fail_count = 0;
		n_compared = 0;
		reset = 1'b1;
		instr_valid = 1'b0;
		instr = '0;
		program_counter_value = 16'h0000;
		flag_overflow = 1'b0;
		flag_irq_enable = 1'b0;
		reg_read_data = 8'h00;
		io_rd_data = 8'h00;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		`CHK("ready_rst", 1'b1, instr_ready)
		`CHK("pc_load_rst", 1'b0, program_counter_load)
		test_branches();
		test_io_bits();
		test_shifts();
		test_op_none();
		test_reset_mid();
		summarize();
	end
endmodule : tb_branch_bitop_shift_exec
